//--- design/scsi_host_port.sv
// How it works
// - Strobes count only with chip select or DMA grant low
// - Index/data low: write loads pointer, read gives aux; high accesses
// - Multiplexed bus address captured by latch strobe
// - DMA grant routes transfers to data register
// - Local mode: grant pin becomes RAM select
// - Local mode strobes write/read sector buffer
// - Transfer ask output, input in local mode
// - DMA byte handshake ask versus grant
// - Burst holds transfer ask while data remains and the FIFO has room
// - Local: ask low stops, releases select, strobes
// - Host parity bit generated and checked
// - SCSI pins open drain, pull low only
// - REQ in as initiator, out as target
// - ACK out as initiator, in as target
// - ATN out as initiator, in as target
// - Phase lines in initiator, out target
// - BSY while arbitrating or connected target
// - SEL while selecting or reselecting
// - Odd parity on SCSI data bus
// - Reset idles and negates all SCSI lines
// - Status register read clears interrupt
// - Indirect access increments pointer except fixed
// - Address latched on latch strobe falling edge
`timescale 1ns/100ps
`default_nettype none
module scsi_host_port import scsi_port_pkg::*; (
   input wire logic clk_i, // 100 MHz clock
   input wire logic reset_n_i, // Master clear, async, low
   input wire logic cs_n_i, // Chip select pin
   input wire logic host_rd_strobe_n_i, // Read strobe pin in
   output logic host_rd_strobe_n_o, // Read strobe pin out
   output logic host_rd_strobe_oe_o, // Read strobe drive
   input wire logic host_wr_strobe_n_i, // Write strobe pin in
   output logic host_wr_strobe_n_o, // Write strobe pin out
   output logic host_wr_strobe_oe_o, // Write strobe drive
   input wire logic index_or_data_sel_i, // Index/data select pin
   input wire logic addr_latch_i, // Address latch strobe pin
   input wire logic [7:0] host_data_i, // Host data pins in
   output logic [7:0] host_data_o, // Host data pins out
   output logic host_data_oe_o, // Host data drive
   input wire logic host_parity_bit_i, // Host parity pin in
   output logic host_parity_bit_o, // Host parity pin out
   output logic host_parity_bit_oe_o, // Host parity drive
   input wire logic dma_grant_n_i, // Grant pin in
   output logic buffer_ram_select_n_o, // Grant pin as RAM select
   output logic buffer_ram_select_oe_o, // RAM select drive
   input wire logic dma_transfer_ask_i, // Transfer ask pin in
   output logic dma_transfer_ask_n_o, // Transfer ask pin out
   output logic dma_transfer_ask_oe_o, // Transfer ask drive
   output logic intrq_o, // Interrupt to host
   input wire scsi_ctl_t scsi_ctl_n_i, // SCSI control pins
   input wire logic [7:0] scsi_data_n_i, // SCSI data pins
   input wire logic scsi_parity_bit_n_i, // SCSI parity pin
   output logic scsi_drive_level_o, // Level on every enabled pin
   output scsi_ctl_t scsi_ctl_oe_o, // SCSI control pull-down
   output logic [7:0] scsi_data_oe_o, // SCSI data pull-down
   output logic scsi_parity_bit_oe_o, // SCSI parity pull-down
   output scsi_pin_t scsi_seen_o, // Sampled SCSI pins
   output logic scsi_parity_err_o, // Bad SCSI parity pulse
   input wire scsi_cmd_t scsi_cmd_i, // Core wants on SCSI
   input wire logic local_buffer_mode_i, // Local buffer mode
   input wire logic burst_mode_i, // Burst DMA
   input wire logic host_parity_en_i, // Check host parity
   input wire logic lb_write_dir_i, // Local: core to RAM
   input wire logic xfer_pending_i, // Data left to move
   input wire logic irq_set_i, // Interrupt event
   output logic [7:0] reg_addr_o, // Register index
   output logic reg_wr_o, // Register write pulse
   output logic reg_rd_o, // Register read pulse
   output logic [7:0] reg_wdata_o, // Register write data
   input wire logic [7:0] reg_rdata_i, // Register read data
   output logic host_parity_err_o, // Bad host parity pulse
   output logic [FIFO_W-1:0] stream_data_o, // Byte toward SCSI
   output logic stream_valid_o, // Stream valid
   input wire logic stream_ready_i, // Stream ready
   input wire logic [7:0] lb_wr_data_i, // Byte toward RAM
   input wire logic lb_wr_valid_i, // Byte valid
   output logic lb_wr_ready_o // Byte taken this cycle
);
   typedef struct packed {
      pin_t s1, s2, s3, f, p;
      lstate_t ls;
      logic [3:0] cnt;
      logic rdir;
      logic [7:0] ptr;
      logic ale_seen;
      logic [7:0] raddr, wdata;
      logic rwr, rrd;
      logic [7:0] hd;
      logic hpar, hd_oe;
      logic intrq, hpe, spe;
      logic drq_n, drq_oe, dwait;
      logic sel_n, sel_oe, rd_n, wr_n, stb_oe;
      logic push;
      logic [7:0] pdata;
      logic wr_take;
      scsi_ctl_t ctl_oe;
      logic [7:0] sd_oe;
      logic sdp_oe, lvl;
   } st_t;

   st_t q, n;
   pin_t pins;
   logic in_rdy, host_on, dma, acc, wr_fall, rd_fall, ale_fall, indirect, step;
   logic dma_grant_n_fall, dma_grant_n_rise, hs_fall, abort, clr;
   logic [7:0] eff;

   function automatic logic [7:0] eff_addr(input logic d, ind, a0, input logic [7:0] ptr);
      if (d) eff_addr = ADDR_DATA;
      else if (ind & ~a0) eff_addr = ADDR_AUX;
      else eff_addr = ptr;
   endfunction : eff_addr

   assign pins = {cs_n_i, host_rd_strobe_n_i, host_wr_strobe_n_i, index_or_data_sel_i,
                  addr_latch_i, dma_grant_n_i, dma_transfer_ask_i, host_parity_bit_i,
                  host_data_i, scsi_ctl_n_i, scsi_parity_bit_n_i, scsi_data_n_i};
   assign host_on = ~local_buffer_mode_i;
   assign dma = host_on & ~q.f.h.dma_grant_n_n;
   assign acc = host_on & (~q.f.h.cs_n | dma);
   assign wr_fall = q.p.h.wr_n & ~q.f.h.wr_n;
   assign rd_fall = q.p.h.rd_n & ~q.f.h.rd_n;
   assign ale_fall = q.p.h.ale & ~q.f.h.ale;
   assign dma_grant_n_fall = q.p.h.dma_grant_n_n & ~q.f.h.dma_grant_n_n;
   assign dma_grant_n_rise = ~q.p.h.dma_grant_n_n & q.f.h.dma_grant_n_n;
   // Until the latch strobe is seen moving it is taken as grounded
   assign indirect = ~q.ale_seen;
   assign eff = eff_addr(dma, indirect, q.f.h.a0, q.ptr);
   assign abort = ~local_buffer_mode_i | ~q.f.h.dma_transfer_ask;
   assign hs_fall = scsi_cmd_i.target ? (q.p.s.ctl.ack & ~q.f.s.ctl.ack)
                                      : (q.p.s.ctl.req & ~q.f.s.ctl.req);

   always_comb begin
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.f = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
      n.p = q.f;
      n.rwr = 1'b0;
      n.rrd = 1'b0;
      n.push = 1'b0;
      n.hpe = 1'b0;
      n.spe = 1'b0;
      n.lvl = 1'b0;
      step = 1'b0;
      clr = 1'b0;
      // Host register side
      n.hd_oe = host_on & ~q.f.h.rd_n & (~q.f.h.cs_n | dma);
      if (host_on) begin
         n.hd = reg_rdata_i;
         n.hpar = ~^reg_rdata_i;
         if (ale_fall) begin
            n.ptr = q.f.h.data;
            n.ale_seen = 1'b1;
         end
         if (acc & wr_fall) begin
            if (indirect & ~dma & ~q.f.h.a0) begin
               n.ptr = q.f.h.data;
            end else begin
               n.rwr = 1'b1;
               n.raddr = eff;
               n.wdata = q.f.h.data;
               step = 1'b1;
               // Byte dropped if the host ignores the withdrawn ask
               if (eff == ADDR_DATA && in_rdy) begin
                  n.push = 1'b1;
                  n.pdata = q.f.h.data;
               end
               if (host_parity_en_i && !(^{q.f.h.data, q.f.h.par})) n.hpe = 1'b1;
            end
         end
         if (acc & rd_fall) begin
            n.rrd = 1'b1;
            n.raddr = eff;
            step = 1'b1;
            clr = eff == ADDR_SCSI_STATUS;
         end
         if (step & indirect & ~dma & q.f.h.a0 && q.ptr != ADDR_AUX && q.ptr != ADDR_DATA &&
             q.ptr != ADDR_CMD) begin
            n.ptr = 8'(q.ptr + 8'h01);
         end
         // Per-byte ask drops on grant and returns after grant ends
         if (dma_grant_n_fall) n.dwait = 1'b1;
         else if (dma_grant_n_rise) n.dwait = 1'b0;
         n.drq_oe = 1'b1;
         n.drq_n = ~(xfer_pending_i & in_rdy &
                     (burst_mode_i | (~q.dwait & q.f.h.dma_grant_n_n)));
      end else begin
         n.drq_oe = 1'b0;
         n.dwait = 1'b0;
         n.drq_n = 1'b1;
      end
      n.intrq = (q.intrq & ~clr) | irq_set_i;
      // Local buffer side
      n.sel_oe = local_buffer_mode_i;
      if (q.ls != L_IDLE && abort) begin
         n.ls = L_IDLE;
         n.sel_n = 1'b1;
         n.stb_oe = 1'b0;
         n.rd_n = 1'b1;
         n.wr_n = 1'b1;
         n.hd_oe = 1'b0;
      end else begin
         case (q.ls)
            L_IDLE: begin
               n.sel_n = 1'b1;
               n.stb_oe = 1'b0;
               n.rd_n = 1'b1;
               n.wr_n = 1'b1;
               n.wr_take = local_buffer_mode_i & q.f.h.dma_transfer_ask & lb_write_dir_i;
               if (q.wr_take & lb_wr_valid_i & ~abort) begin
                  n.wr_take = 1'b0;
                  n.hd = lb_wr_data_i;
                  n.hpar = ~^lb_wr_data_i;
                  n.hd_oe = 1'b1;
                  n.wr_n = 1'b0;
                  n.rdir = 1'b0;
               end else if (~abort & ~lb_write_dir_i & in_rdy) begin
                  n.rd_n = 1'b0;
                  n.rdir = 1'b1;
               end
               if (~n.wr_n | ~n.rd_n) begin
                  n.sel_n = 1'b0;
                  n.stb_oe = 1'b1;
                  n.cnt = 4'(STROBE_CYC - 1);
                  n.ls = L_ACT;
               end
            end
            L_ACT: begin
               n.hd_oe = q.hd_oe;
               if (q.cnt == '0) begin
                  if (q.rdir) begin
                     n.push = 1'b1;
                     n.pdata = q.f.h.data;
                  end
                  n.rd_n = 1'b1;
                  n.wr_n = 1'b1;
                  n.cnt = 4'(GAP_CYC - 1);
                  n.ls = L_GAP;
               end else begin
                  n.cnt = q.cnt - 4'h1;
               end
            end
            L_GAP: begin
               // Data held through the gap for write hold time
               n.hd_oe = q.hd_oe;
               if (q.cnt == '0) n.ls = L_IDLE;
               else n.cnt = q.cnt - 4'h1;
            end
            default: n.ls = L_IDLE;
         endcase
      end
      // SCSI side: only pull-downs, never a driven high
      n.ctl_oe = scsi_cmd_i.want & (scsi_cmd_i.target ? TGT_MASK : INI_MASK);
      n.ctl_oe.bsy = scsi_cmd_i.arbitrating | (scsi_cmd_i.target & scsi_cmd_i.connected);
      n.ctl_oe.sel = scsi_cmd_i.selecting;
      n.sd_oe = scsi_cmd_i.drive ? scsi_cmd_i.data : 8'h00;
      n.sdp_oe = scsi_cmd_i.drive & ~^scsi_cmd_i.data;
      // Pins are low-true, so odd asserted bits means even pin ones
      if (hs_fall & ~scsi_cmd_i.drive) n.spe = ^{q.f.s.data, q.f.s.par};
   end

   // Registers clear under reset, pin samplers load idle levels: SCSI lines negated
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) q <= {{5{PIN_IDLE}}, {($bits(st_t) - 5 * $bits(pin_t)){1'b0}}};
      else q <= n;
   end

   byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_data_i(q.pdata),
      .in_valid_i(q.push),
      .in_ready_o(in_rdy),
      .out_data_o(stream_data_o),
      .out_valid_o(stream_valid_o),
      .out_ready_i(stream_ready_i)
   );

   assign host_rd_strobe_n_o = q.rd_n;
   assign host_rd_strobe_oe_o = q.stb_oe;
   assign host_wr_strobe_n_o = q.wr_n;
   assign host_wr_strobe_oe_o = q.stb_oe;
   assign host_data_o = q.hd;
   assign host_data_oe_o = q.hd_oe;
   assign host_parity_bit_o = q.hpar;
   assign host_parity_bit_oe_o = q.hd_oe;
   assign buffer_ram_select_n_o = q.sel_n;
   assign buffer_ram_select_oe_o = q.sel_oe;
   assign dma_transfer_ask_n_o = q.drq_n;
   assign dma_transfer_ask_oe_o = q.drq_oe;
   assign intrq_o = q.intrq;
   assign scsi_drive_level_o = q.lvl;
   assign scsi_ctl_oe_o = q.ctl_oe;
   assign scsi_data_oe_o = q.sd_oe;
   assign scsi_parity_bit_oe_o = q.sdp_oe;
   assign scsi_seen_o = q.f.s;
   assign scsi_parity_err_o = q.spe;
   assign reg_addr_o = q.raddr;
   assign reg_wr_o = q.rwr;
   assign reg_rd_o = q.rrd;
   assign reg_wdata_o = q.wdata;
   assign host_parity_err_o = q.hpe;
   assign lb_wr_ready_o = q.wr_take;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   property p_no_cs;
      (wr_fall & q.f.h.cs_n & q.f.h.dma_grant_n_n) |=> !q.rwr;
   endproperty
   a_no_cs: assert property (p_no_cs) else $error("write taken without select");
   property p_dma_data;
      (acc & wr_fall & dma) |=> q.rwr && q.raddr == ADDR_DATA;
   endproperty
   a_dma_data: assert property (p_dma_data) else $error("grant write not to data");
   property p_index_load;
      (acc & wr_fall & indirect & ~dma & ~q.f.h.a0) |=> q.ptr == $past(q.f.h.data) && !q.rwr;
   endproperty
   a_index_load: assert property (p_index_load) else $error("pointer not loaded");
   property p_latch;
      (host_on & ale_fall) |=> q.ptr == $past(q.f.h.data) && q.ale_seen;
   endproperty
   a_latch: assert property (p_latch) else $error("address not latched");
   property p_step;
      (acc & rd_fall & indirect & ~dma & q.f.h.a0 && q.ptr < ADDR_CMD)
         |=> q.ptr == 8'($past(q.ptr) + 8'h01);
   endproperty
   a_step: assert property (p_step) else $error("pointer did not step");
   property p_stop;
      (q.ls != L_IDLE && abort) |=> !q.stb_oe && q.sel_n && q.ls == L_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("local burst not stopped");
   property p_sel_with_stb;
      q.stb_oe |-> q.sel_oe && !q.sel_n;
   endproperty
   a_sel_with_stb: assert property (p_sel_with_stb) else $error("strobe without select");
   property p_burst;
      (host_on & burst_mode_i & xfer_pending_i & in_rdy) |=> !q.drq_n && q.drq_oe;
   endproperty
   a_burst: assert property (p_burst) else $error("burst ask not held");
   property p_parity;
      (q.sd_oe != 8'h00) |-> ^{q.sd_oe, q.sdp_oe};
   endproperty
   a_parity: assert property (p_parity) else $error("SCSI parity not odd");
   property p_irq_clear;
      (acc & rd_fall & eff == ADDR_SCSI_STATUS & ~irq_set_i) |=> !q.intrq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");
   c_local_read: cover property (q.ls == L_ACT && q.rdir ##[1:20] q.push);
   c_dma_push: cover property (dma & wr_fall ##1 q.push);
   c_step: cover property (acc & wr_fall & indirect & q.f.h.a0 ##1 q.rwr);
endmodule : scsi_host_port
`default_nettype wire

//--- design/scsi_port_pkg.sv
package scsi_port_pkg;
   localparam int CLK_NS = 10;
   // Local-buffer strobe must outlast the three-stage pin sampler
   localparam int STROBE_NS = 60;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_NS = 20;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 8;
   localparam logic [7:0] ADDR_SCSI_STATUS = 8'h17;
   localparam logic [7:0] ADDR_CMD = 8'h18;
   localparam logic [7:0] ADDR_DATA = 8'h19;
   localparam logic [7:0] ADDR_AUX = 8'h1f;

   typedef struct packed {
      logic req, ack, atn, msg, cd, io, bsy, sel;
   } scsi_ctl_t;

   // Lines each role may drive
   localparam scsi_ctl_t TGT_MASK = 8'h9c;
   localparam scsi_ctl_t INI_MASK = 8'h60;

   typedef struct packed {
      logic cs_n, rd_n, wr_n, a0, ale, dma_grant_n_n, dma_transfer_ask, par;
      logic [7:0] data;
   } host_pin_t;

   typedef struct packed {
      scsi_ctl_t ctl;
      logic par;
      logic [7:0] data;
   } scsi_pin_t;

   typedef struct packed {
      host_pin_t h;
      scsi_pin_t s;
   } pin_t;
   localparam pin_t PIN_IDLE = {8'he4, 8'h00, 17'h1ffff};

   typedef struct packed {
      logic target, arbitrating, connected, selecting, drive;
      scsi_ctl_t want;
      logic [7:0] data;
   } scsi_cmd_t;

   typedef enum logic [1:0] {L_IDLE, L_ACT, L_GAP} lstate_t;
endpackage : scsi_port_pkg

//--- design/byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module byte_fifo import scsi_port_pkg::*; #(
   parameter int WIDTH = FIFO_W,
   parameter int DEPTH = FIFO_D
) (
   input wire logic clk_i, // Clock
   input wire logic reset_n_i, // Async reset, low
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Room for a word
   output logic [WIDTH-1:0] out_data_o, // Oldest word
   output logic out_valid_o, // Word present
   input wire logic out_ready_i // Drain request
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("byte_fifo depth must be a power of two");
   end

   typedef struct packed {
      logic [AW-1:0] wp, rp;
      logic [AW:0] cnt;
   } fst_t;

   fst_t st_q, st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready_o = st_q.cnt != (AW+1)'(DEPTH);
   assign out_valid_o = st_q.cnt != '0;
   assign out_data_o = mem[st_q.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb begin
      st_d = st_q;
      if (push) st_d.wp = st_q.wp + 1'b1;
      if (pop) st_d.rp = st_q.rp + 1'b1;
      if (push & ~pop) st_d.cnt = st_q.cnt + 1'b1;
      else if (pop & ~push) st_d.cnt = st_q.cnt - 1'b1;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) st_q <= '0;
      else st_q <= st_d;
   end

   // Storage needs no reset; count guards every read
   always_ff @(posedge clk_i) begin
      if (push) mem[st_q.wp] <= in_data_i;
   end
endmodule : byte_fifo
`default_nettype wire

//--- test/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_bus_model import scsi_port_pkg::*; #(
   parameter logic [7:0] RAM_BYTE = 8'h6b
) (
   input wire logic clk_i, // Clock
   input wire logic dut_rd_n_i, // Read strobe driven by block
   input wire logic dut_rd_oe_i, // Read strobe drive
   input wire logic dut_wr_n_i, // Write strobe driven by block
   input wire logic dut_wr_oe_i, // Write strobe drive
   input wire logic [7:0] dut_d_i, // Data driven by block
   input wire logic dut_par_i, // Parity driven by block
   input wire logic dut_d_oe_i, // Data drive
   input wire logic dut_sel_n_i, // RAM select from block
   input wire logic dut_sel_oe_i, // RAM select drive
   input wire logic dut_ask_n_i, // Transfer ask from block
   input wire logic dut_ask_oe_i, // Transfer ask drive
   output logic cs_n_o, // Chip select pin
   output logic rd_n_o, // Read strobe pin level
   output logic wr_n_o, // Write strobe pin level
   output logic a0_o, // Index/data select pin
   output logic ale_o, // Address latch pin
   output logic [7:0] d_o, // Data pin level
   output logic par_o, // Parity pin level
   output logic grant_n_o, // Grant/select pin level
   output logic ask_o // Transfer ask pin level
);
   logic cs_n_q = 1'b1, rd_q = 1'b1, wr_q = 1'b1, a0_q = 1'b0, g_q = 1'b1;
   logic ale_q = 1'b0;
   logic ask_q = 1'b0, drv_q = 1'b0, bad_q = 1'b0, ram_rd;
   logic [7:0] d_q = 8'h00, last_q = 8'h00;
   assign cs_n_o = cs_n_q;
   assign a0_o = a0_q;
   assign ale_o = ale_q;
   assign rd_n_o = dut_rd_oe_i ? dut_rd_n_i : rd_q;
   assign wr_n_o = dut_wr_oe_i ? dut_wr_n_i : wr_q;
   // Shared pin has a pull-up, so it idles high when nobody drives it
   assign grant_n_o = dut_sel_oe_i ? dut_sel_n_i : g_q;
   assign ask_o = dut_ask_oe_i ? dut_ask_n_i : ask_q;
   assign ram_rd = dut_sel_oe_i && !dut_sel_n_i && !rd_n_o;
   // A floating bus shows the inverse of its last byte, never a stale copy
   assign d_o = dut_d_oe_i ? dut_d_i : drv_q ? d_q : ram_rd ? RAM_BYTE : ~last_q;
   assign par_o = dut_d_oe_i ? dut_par_i : bad_q ^ ~^d_o;
   always @(posedge clk_i) begin
      last_q <= d_o;
   end

   // Kind 0: chip-select access, 1: grant cycle, 2: strobes with nothing selected
   task automatic cyc(input logic [1:0] kind, input logic wr, input logic a0,
                      input logic [7:0] d, output logic [8:0] q, output logic ask_seen);
      @(negedge clk_i);
      cs_n_q <= (kind != 2'd0);
      g_q <= (kind != 2'd1);
      a0_q <= a0;
      d_q <= d;
      drv_q <= wr;
      @(negedge clk_i);
      if (wr) wr_q <= 1'b0;
      else rd_q <= 1'b0;
      repeat (10) @(negedge clk_i);
      q = {par_o, d_o};
      ask_seen = ask_o;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      @(negedge clk_i);
      cs_n_q <= 1'b1;
      g_q <= 1'b1;
      drv_q <= 1'b0;
      repeat (6) @(negedge clk_i);
   endtask : cyc

   task automatic latch(input logic [7:0] d);
      @(negedge clk_i);
      d_q <= d;
      drv_q <= 1'b1;
      ale_q <= 1'b1;
      repeat (4) @(negedge clk_i);
      ale_q <= 1'b0;
      repeat (4) @(negedge clk_i);
      drv_q <= 1'b0;
   endtask : latch

   task automatic set_ask(input logic v);
      @(negedge clk_i);
      ask_q <= v;
   endtask : set_ask
endmodule : host_bus_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench import scsi_port_pkg::*; ;
   logic clk = 1'b0, rst_n = 1'b0;
   wire logic cs_n, rd_n, wr_n, a0, ale, hpar, grant_n, ask;
   wire logic [7:0] hd;
   logic rd_o, rd_oe, wr_o, wr_oe, hd_oe, hpar_o, hpar_oe, sel_n, sel_oe, ask_n, ask_oe;
   logic intrq, drive_lvl, par_oe, perr, reg_wr, reg_rd, s_valid, ev_rd, hs;
   logic [7:0] hd_o, data_oe, reg_addr, wdata, rdata, s_data, ev_addr, ev_wd;
   logic [8:0] hq;
   scsi_ctl_t ctl_oe, ctl_n = '1;
   scsi_cmd_t cmd = '0;
   logic [7:0] sd_n = 8'hff;
   logic sp_n = 1'b1, lbm = 1'b0, burst = 1'b0, pend = 1'b0, irq = 1'b0, s_rdy = 1'b0;
   logic lwd = 1'b0, lwv = 1'b0, hperr;
   int err_total = 0, n_tests = 0, ev_n = 0, pe_n = 0, cyc_n = 0, hp_n = 0;
   // Register file stand-in: read data is a fixed function of the index
   assign rdata = reg_addr ^ 8'h5a;

   scsi_host_port i_scsi_host_port (
      .clk_i(clk), .reset_n_i(rst_n), .cs_n_i(cs_n), .host_rd_strobe_n_i(rd_n),
      .host_rd_strobe_n_o(rd_o), .host_rd_strobe_oe_o(rd_oe), .host_wr_strobe_n_i(wr_n),
      .host_wr_strobe_n_o(wr_o), .host_wr_strobe_oe_o(wr_oe), .index_or_data_sel_i(a0),
      .addr_latch_i(ale), .host_data_i(hd), .host_data_o(hd_o), .host_data_oe_o(hd_oe),
      .host_parity_bit_i(hpar), .host_parity_bit_o(hpar_o), .host_parity_bit_oe_o(hpar_oe),
      .dma_grant_n_i(grant_n), .buffer_ram_select_n_o(sel_n), .buffer_ram_select_oe_o(sel_oe),
      .dma_transfer_ask_i(ask), .dma_transfer_ask_n_o(ask_n), .dma_transfer_ask_oe_o(ask_oe),
      .intrq_o(intrq), .scsi_ctl_n_i(ctl_n), .scsi_data_n_i(sd_n), .scsi_parity_bit_n_i(sp_n),
      .scsi_drive_level_o(drive_lvl), .scsi_ctl_oe_o(ctl_oe), .scsi_data_oe_o(data_oe),
      .scsi_parity_bit_oe_o(par_oe), .scsi_seen_o(), .scsi_parity_err_o(perr),
      .scsi_cmd_i(cmd), .local_buffer_mode_i(lbm), .burst_mode_i(burst),
      .host_parity_en_i(1'b1), .lb_write_dir_i(lwd), .xfer_pending_i(pend),
      .irq_set_i(irq), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata), .host_parity_err_o(hperr),
      .stream_data_o(s_data), .stream_valid_o(s_valid), .stream_ready_i(s_rdy),
      .lb_wr_data_i(8'h3c), .lb_wr_valid_i(lwv), .lb_wr_ready_o()
   );

   host_bus_model i_host_bus_model (
      .clk_i(clk), .dut_rd_n_i(rd_o), .dut_rd_oe_i(rd_oe), .dut_wr_n_i(wr_o),
      .dut_wr_oe_i(wr_oe), .dut_d_i(hd_o), .dut_par_i(hpar_o), .dut_d_oe_i(hd_oe),
      .dut_sel_n_i(sel_n), .dut_sel_oe_i(sel_oe), .dut_ask_n_i(ask_n), .dut_ask_oe_i(ask_oe),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .a0_o(a0), .ale_o(ale), .d_o(hd),
      .par_o(hpar), .grant_n_o(grant_n), .ask_o(ask)
   );

   always #5 clk = ~clk;

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (reg_wr || reg_rd) begin
         ev_n <= ev_n + 1;
         ev_addr <= reg_addr;
         ev_wd <= wdata;
         ev_rd <= reg_rd;
      end
      if (perr) pe_n <= pe_n + 1;
      if (hperr) hp_n <= hp_n + 1;
      if (cyc_n == 6000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic hb(input logic [1:0] kind, input logic wr, input logic a, input logic [7:0] d);
      i_host_bus_model.cyc(kind, wr, a, d, hq, hs);
   endtask : hb

   task automatic t_indirect;
      int n;
      n = ev_n;
      hb(2, 1, 1, 8'h33);
      hb(2, 0, 1, 8'h00);
      chk(ev_n - n, 0);
      hb(0, 1, 0, 8'h05);
      hb(0, 1, 1, 8'ha5);
      chk({ev_addr, ev_wd}, 16'h05a5);
      hb(0, 1, 1, 8'h11);
      chk(ev_addr, 8'h06);
      hb(0, 0, 0, 8'h00);
      chk({ev_rd, ev_addr}, 9'h11f);
      chk(hq[7:0], 8'h1f ^ 8'h5a);
      chk(^hq, 1'b1);
      hb(0, 1, 0, 8'h19);
      hb(0, 0, 1, 8'h01);
      hb(0, 0, 1, 8'h00);
      chk({ev_rd, ev_addr}, 9'h119);
   endtask : t_indirect

   task automatic t_irq;
      @(negedge clk);
      irq <= 1'b1;
      @(negedge clk);
      irq <= 1'b0;
      repeat (2) @(negedge clk);
      chk(intrq, 1'b1);
      hb(0, 1, 0, 8'h17);
      hb(0, 0, 1, 8'h00);
      chk({intrq, ev_addr}, 9'h017);
   endtask : t_irq

   // Single handshake, then burst fill to full while the stream side stalls
   task automatic t_dma;
      logic [7:0] exp [8];
      int k;
      pend <= 1'b1;
      repeat (6) @(negedge clk);
      chk({ask_oe, ask_n}, 2'b10);
      hb(1, 1, 0, 8'hc1);
      chk({hs, ev_addr}, 9'h119);
      repeat (6) @(negedge clk);
      chk(ask_n, 1'b0);
      exp[0] = 8'hc1;
      burst <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         exp[i + 1] = 8'h40 + i[7:0];
         hb(1, 1, 1, exp[i + 1]);
         chk(hs, i == 6);
      end
      hb(1, 1, 1, 8'hee);
      chk(ask_n, 1'b1);
      s_rdy <= 1'b1;
      k = 0;
      for (int c = 0; c < 40; c++) begin
         if (s_valid === 1'b1 && k < 8) begin
            chk(s_data, exp[k]);
            k++;
         end
         @(negedge clk);
      end
      chk({k[7:0], s_valid}, 9'h010);
      pend <= 1'b0;
      burst <= 1'b0;
   endtask : t_dma

   task automatic t_scsi;
      scsi_cmd_t c [2];
      logic [16:0] e [2];
      int n;
      c[0] = {5'b01011, 8'hff, 8'h03};
      e[0] = {8'h63, 8'h03, 1'b1};
      c[1] = {5'b10100, 8'hff, 8'h07};
      e[1] = {8'h9e, 8'h00, 1'b0};
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         cmd <= c[i];
         repeat (2) @(negedge clk);
         chk({ctl_oe, data_oe}, e[i][16:1]);
         chk({drive_lvl, par_oe}, {1'b0, e[i][0]});
      end
      cmd <= '0;
      sd_n <= ~8'h03;
      for (int i = 0; i < 2; i++) begin
         n = pe_n;
         sp_n <= (i == 0);
         repeat (4) @(negedge clk);
         ctl_n.req <= 1'b0;
         repeat (8) @(negedge clk);
         ctl_n.req <= 1'b1;
         repeat (8) @(negedge clk);
         chk(pe_n - n, i == 0);
      end
   endtask : t_scsi

   task automatic t_local;
      int k;
      lbm <= 1'b1;
      i_host_bus_model.set_ask(1'b1);
      k = 0;
      while (rd_n !== 1'b0 && k < 50) begin
         @(negedge clk);
         k++;
      end
      chk({sel_oe, sel_n, rd_oe, ask_oe}, 4'b1010);
      k = 0;
      while (rd_n === 1'b0 && k < 50) begin
         @(negedge clk);
         k++;
      end
      chk(k, STROBE_CYC);
      k = 0;
      while (s_valid !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk(s_data, 8'h6b);
      lwd <= 1'b1;
      lwv <= 1'b1;
      wait (wr_n === 1'b0);
      @(negedge clk);
      chk({hd, wr_oe, sel_n}, 10'h0f2);
      lwd <= 1'b0;
      lwv <= 1'b0;
      i_host_bus_model.set_ask(1'b0);
      repeat (5) @(negedge clk);
      chk({sel_n, rd_oe, wr_oe, hd_oe}, 4'b1000);
      lbm <= 1'b0;
      repeat (20) @(negedge clk);
   endtask : t_local

   task automatic t_direct;
      i_host_bus_model.latch(8'h12);
      i_host_bus_model.bad_q <= 1'b1;
      hb(0, 1, 0, 8'h77);
      i_host_bus_model.bad_q <= 1'b0;
      chk({ev_addr, ev_wd}, 16'h1277);
      chk(hp_n, 1);
      i_host_bus_model.latch(8'h0b);
      hb(0, 0, 0, 8'h00);
      chk({ev_rd, ev_addr}, 9'h10b);
      chk(hq[7:0], 8'h0b ^ 8'h5a);
   endtask : t_direct

   initial begin
      repeat (4) @(negedge clk);
      chk({ctl_oe, data_oe}, 16'h0000);
      chk({par_oe, sel_oe, rd_oe, wr_oe, hd_oe, ask_oe}, 6'h00);
      rst_n <= 1'b1;
      repeat (5) @(negedge clk);
      t_indirect();
      t_irq();
      t_dma();
      t_scsi();
      t_local();
      t_direct();
      close_out();
   end
endmodule : testbench
`default_nettype wire
